/* File: logic/mac_event_flags_consts.svh */
`ifndef MAC_EVENT_FLAGS_CONSTS_SVH
`define MAC_EVENT_FLAGS_CONSTS_SVH

// Register byte offsets within the status slice.
`define OFS_PAUSE_SA_LOWER   8'h24
`define OFS_PAUSE_SA_UPPER   8'h28
`define OFS_EVENT_FLAGS      8'h2C
`define OFS_EVENT_MASK       8'h30

// Field layout and reset values.
`define SA_HALF_W            24
`define SA_HALF_RST          24'h00_0000
`define EVT_W                10
`define EVT_RST              10'h000
`define MASK_RST             10'h000
`define RDATA_ZERO           32'h0000_0000

// Event bit positions in the flag register.
`define EVT_TX_ABORT         0
`define EVT_TX_OVERSIZE      1
`define EVT_TX_FIFO_OVF      2
`define EVT_TX_HOST_JAM      3
`define EVT_TX_RETRANSMIT    4
`define EVT_RX_JUNK          5
`define EVT_RX_EXT_ERR       6
`define EVT_RX_EXT           7
`define EVT_RX_SHORT_PREAM   8
`define EVT_RX_SHORT_GAP     9

`endif

/* File: logic/mac_status_pkg.sv */
package mac_status_pkg;
  // Decoded register selected by a bus address.
  typedef enum {
    REG_NONE,
    REG_SA_LOWER,
    REG_SA_UPPER,
    REG_FLAGS,
    REG_MASK
  } reg_sel_e;
endpackage : mac_status_pkg

/* File: logic/sticky_flag_bit.sv */
`timescale 1ns/1ns
`default_nettype none

// One sticky event flag: set by a hardware pulse, cleared by a one written by software.
module sticky_flag_bit (
  input  wire logic sys_clk,   // System clock.
  input  wire logic rst_n,     // Asynchronous reset, active low.
  input  wire logic setPulse,  // Event from the datapath.
  input  wire logic clrPulse,  // Software clear (write of one).
  output logic      flag_r     // Sticky flag.
);

  // Set is checked first so an event in the clear cycle is never lost.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_r <= 1'b0;
    end else if (setPulse) begin
      flag_r <= 1'b1;
    end else if (clrPulse) begin
      flag_r <= 1'b0;
    end
  end

endmodule : sticky_flag_bit

`default_nettype wire

/* File: logic/mac_event_flags_status.sv */
// The strobed register port and the register addresses are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "mac_event_flags_consts.svh"

module mac_event_flags_status #(
  parameter int ADDR_W = 8  // Register address width in bits.
) (
  input  wire logic              sys_clk,           // System clock, 250 MHz.
  input  wire logic              rst_n,             // Asynchronous reset, active low.
  input  wire logic [ADDR_W-1:0] regAddr,           // Register byte address.
  input  wire logic [31:0]       regWdata,          // Write data.
  input  wire logic              regWr,             // Write strobe.
  input  wire logic              regRd,             // Read strobe.
  output logic      [31:0]       regRdata,          // Read data, one cycle after regRd.
  input  wire logic              rxShortGap,        // Pulse: gap under twelve bytes.
  input  wire logic              rxShortPreamble,   // Pulse: preamble under eight bytes.
  input  wire logic              rxCarrierExtend,   // Pulse: carrier extend seen.
  input  wire logic              rxCarrierExtErr,   // Pulse: carrier extend error.
  input  wire logic              rxJunk,            // Pulse: bytes not part of a frame.
  input  wire logic              txRetransmit,      // Pulse: retransmit asked of host.
  input  wire logic              txHostJam,         // Pulse: host jam request.
  input  wire logic              txFifoOverflow,    // Pulse: transmit FIFO overrun.
  input  wire logic              txOversizeFrame,   // Pulse: frame over 64K bytes.
  input  wire logic              txAbortDone,       // Pulse: host abort carried out.
  output logic      [47:0]       pauseSourceAddr,   // Source address for pause frames.
  output logic                   irq                // Level interrupt, active high.
);

  logic [`SA_HALF_W-1:0]   pause_sa_upper_bytes;
  logic [`SA_HALF_W-1:0]   pause_sa_lower_bytes;
  logic [`EVT_W-1:0]       eventMask_r;
  logic [`EVT_W-1:0]       eventFlags;
  logic [`EVT_W-1:0]       eventIn;
  logic [`EVT_W-1:0]       flagClr;
  mac_status_pkg::reg_sel_e regSel;

  // Address decode shared by reads and writes.
  always_comb begin
    case (regAddr)
      ADDR_W'(`OFS_PAUSE_SA_LOWER): regSel = mac_status_pkg::REG_SA_LOWER;
      ADDR_W'(`OFS_PAUSE_SA_UPPER): regSel = mac_status_pkg::REG_SA_UPPER;
      ADDR_W'(`OFS_EVENT_FLAGS):    regSel = mac_status_pkg::REG_FLAGS;
      ADDR_W'(`OFS_EVENT_MASK):     regSel = mac_status_pkg::REG_MASK;
      default:                      regSel = mac_status_pkg::REG_NONE;
    endcase
  end

  // Gather the datapath event pulses into their flag positions.
  always_comb begin
    eventIn                       = `EVT_RST;
    eventIn[`EVT_RX_SHORT_GAP]    = rxShortGap;
    eventIn[`EVT_RX_SHORT_PREAM]  = rxShortPreamble;
    eventIn[`EVT_RX_EXT]          = rxCarrierExtend;
    eventIn[`EVT_RX_EXT_ERR]      = rxCarrierExtErr;
    eventIn[`EVT_RX_JUNK]         = rxJunk;
    eventIn[`EVT_TX_RETRANSMIT]   = txRetransmit;
    eventIn[`EVT_TX_HOST_JAM]     = txHostJam;
    eventIn[`EVT_TX_FIFO_OVF]     = txFifoOverflow;
    eventIn[`EVT_TX_OVERSIZE]     = txOversizeFrame;
    eventIn[`EVT_TX_ABORT]        = txAbortDone;
  end

  // Only written ones clear; zeros in the write data leave flags alone.
  assign flagClr = (regWr && regSel == mac_status_pkg::REG_FLAGS) ?
                   regWdata[`EVT_W-1:0] : `EVT_RST;

  // One sticky cell per event; each cell lets a set win over a clear.
  genvar gi;
  generate
    for (gi = 0; gi < `EVT_W; gi++) begin : gFlag
      sticky_flag_bit uFlag (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .setPulse (eventIn[gi]),
        .clrPulse (flagClr[gi]),
        .flag_r   (eventFlags[gi])
      );
    end
  endgenerate

  // Upper address half.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pause_sa_upper_bytes <= `SA_HALF_RST;
    end else if (regWr && regSel == mac_status_pkg::REG_SA_UPPER) begin
      pause_sa_upper_bytes <= regWdata[`SA_HALF_W-1:0];
    end
  end

  // Lower address half.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pause_sa_lower_bytes <= `SA_HALF_RST;
    end else if (regWr && regSel == mac_status_pkg::REG_SA_LOWER) begin
      pause_sa_lower_bytes <= regWdata[`SA_HALF_W-1:0];
    end
  end

  // Full address registered so the transmit path sees a clean, glitch-free value.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pauseSourceAddr <= {`SA_HALF_RST, `SA_HALF_RST};
    end else begin
      pauseSourceAddr <= {pause_sa_upper_bytes, pause_sa_lower_bytes};
    end
  end

  // Interrupt mask, same layout as the flags.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      eventMask_r <= `MASK_RST;
    end else if (regWr && regSel == mac_status_pkg::REG_MASK) begin
      eventMask_r <= regWdata[`EVT_W-1:0];
    end
  end

  // Interrupt follows the flags one cycle later, since the output is registered.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(eventFlags & eventMask_r);
    end
  end

  // Read data stands only in the cycle after the strobe; unmapped reads return zero.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdata <= `RDATA_ZERO;
    end else if (regRd) begin
      case (regSel)
        mac_status_pkg::REG_SA_LOWER: regRdata <= {8'h00, pause_sa_lower_bytes};
        mac_status_pkg::REG_SA_UPPER: regRdata <= {8'h00, pause_sa_upper_bytes};
        mac_status_pkg::REG_FLAGS:    regRdata <= {22'h00_0000, eventFlags};
        mac_status_pkg::REG_MASK:     regRdata <= {22'h00_0000, eventMask_r};
        default:                      regRdata <= `RDATA_ZERO;
      endcase
    end else begin
      regRdata <= `RDATA_ZERO;
    end
  end

endmodule : mac_event_flags_status

`default_nettype wire

/* File: verification/mac_event_flags_status_monitor.sv */
`timescale 1ns/1ns
`default_nettype none
`include "mac_event_flags_consts.svh"
// The flags are internal, so each flag check ties an event or a write to a later read; address checks watch pauseSourceAddr.
module mac_event_flags_status_monitor #(
  parameter int ADDR_W = 8  // Address width.
) (
  input wire logic              sys_clk,          // Clock.
  input wire logic              rst_n,            // Reset, active low.
  input wire logic [ADDR_W-1:0] regAddr,          // Address.
  input wire logic [31:0]       regWdata,         // Write data.
  input wire logic              regWr,            // Write strobe.
  input wire logic              regRd,            // Read strobe.
  input wire logic [31:0]       regRdata,         // Read data.
  input wire logic              rxShortGap,       // Event.
  input wire logic              rxShortPreamble,  // Event.
  input wire logic              rxJunk,           // Event.
  input wire logic              txAbortDone,      // Event.
  input wire logic [47:0]       pauseSourceAddr   // Pause address.
);
  localparam int J = `EVT_RX_JUNK;
  // Decoded strobes.
  wire logic rdF  = regRd && regAddr == `OFS_EVENT_FLAGS;
  wire logic wrF  = regWr && regAddr == `OFS_EVENT_FLAGS;
  wire logic wrU  = regWr && regAddr == `OFS_PAUSE_SA_UPPER;
  wire logic wrLo = regWr && regAddr == `OFS_PAUSE_SA_LOWER;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  property p_upper; wrU |-> ##2 pauseSourceAddr[47:24] == $past(regWdata[23:0], 2); endproperty
  a_upper: assert property (p_upper) else $error("Upper half not applied.");
  property p_lower; wrLo |-> ##2 pauseSourceAddr[23:0] == $past(regWdata[23:0], 2); endproperty
  a_lower: assert property (p_lower) else $error("Lower half not applied.");
  property p_gap; rxShortGap ##1 rdF |=> regRdata[`EVT_RX_SHORT_GAP]; endproperty
  a_gap: assert property (p_gap) else $error("Gap flag not set.");
  property p_pream; rdF && $past(rxShortPreamble) |=> regRdata[`EVT_RX_SHORT_PREAM]; endproperty
  a_pream: assert property (p_pream) else $error("Preamble flag not set.");
  property p_junk; rxJunk ##1 rdF |=> regRdata[J]; endproperty
  a_junk: assert property (p_junk) else $error("Junk flag not set.");
  property p_abort; txAbortDone ##1 rdF |=> regRdata[`EVT_TX_ABORT]; endproperty
  a_abort: assert property (p_abort) else $error("Abort flag not set.");
  property p_clear; wrF && regWdata[J] && !rxJunk ##1 rdF |=> !regRdata[J]; endproperty
  a_clear: assert property (p_clear) else $error("Flag not cleared.");
  property p_setwin; wrF && regWdata[J] && rxJunk ##1 rdF |=> regRdata[J]; endproperty
  a_setwin: assert property (p_setwin) else $error("Clear beat event.");
endmodule : mac_event_flags_status_monitor
bind mac_event_flags_status mac_event_flags_status_monitor #(.ADDR_W(ADDR_W)) mon (.sys_clk(sys_clk),
  .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
  .regRdata(regRdata), .rxShortGap(rxShortGap), .rxShortPreamble(rxShortPreamble),
  .rxJunk(rxJunk), .txAbortDone(txAbortDone), .pauseSourceAddr(pauseSourceAddr));
`default_nettype wire

/* File: verification/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
`include "mac_event_flags_consts.svh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin failures++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module testbench;
  logic        sys_clk = 0, rst_n = 0, regWr = 0, regRd = 0, irq;
  logic [7:0]  regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0000_0000, regRdata, d, u;
  logic [47:0] pauseSourceAddr;
  logic [9:0]  evt = 10'h000, expF = 10'h000, expM = 10'h000;
  int          failures = 0, tests_run = 0, seed = 32'h8abb;
  mac_event_flags_status #(.ADDR_W(8)) dut (.sys_clk(sys_clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .irq(irq),
    .rxShortGap(evt[`EVT_RX_SHORT_GAP]), .rxShortPreamble(evt[`EVT_RX_SHORT_PREAM]),
    .rxCarrierExtend(evt[`EVT_RX_EXT]), .rxCarrierExtErr(evt[`EVT_RX_EXT_ERR]),
    .rxJunk(evt[`EVT_RX_JUNK]), .txRetransmit(evt[`EVT_TX_RETRANSMIT]),
    .txHostJam(evt[`EVT_TX_HOST_JAM]), .txFifoOverflow(evt[`EVT_TX_FIFO_OVF]),
    .txOversizeFrame(evt[`EVT_TX_OVERSIZE]), .txAbortDone(evt[`EVT_TX_ABORT]),
    .pauseSourceAddr(pauseSourceAddr));
  initial forever #2 sys_clk = ~sys_clk;
  // Write-one clears, and an event in the same cycle wins over the clear.
  function automatic logic [9:0] nxtF(logic [9:0] f, logic [9:0] clr, logic [9:0] ev);
    return (f & ~clr) | ev;
  endfunction : nxtF
  // Leaves the strobe high so writes run back to back; the following read drops it.
  task automatic wr(logic [7:0] a, logic [31:0] dv, logic [9:0] ev);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWdata <= dv;
    evt      <= ev;
    expF = nxtF(expF, (a == `OFS_EVENT_FLAGS) ? dv[9:0] : 10'h000, ev);
    if (a == `OFS_EVENT_MASK) expM = dv[9:0];
    @(posedge sys_clk);
  endtask : wr
  // Read data stand only in the cycle after the strobe, so they are sampled there.
  task automatic rd(logic [7:0] a, logic [31:0] x);
    regRd   <= 1'b1;
    regWr   <= 1'b0;
    evt     <= 10'h000;
    regAddr <= a;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1 `CHK(regRdata, x)
    `CHK(irq, |(expF & expM))
    @(posedge sys_clk);
  endtask : rd
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  // A hang is cut short here and reported as a mismatch.
  initial begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    summarize();
  end
  // Main sequence: reset values, address halves, each event, then random traffic.
  initial begin
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    foreach (u[i]) if (i < 5) rd(8'h24 + 8'(i * 4), 32'h0000_0000);
    $display("reset values done");
    repeat (4) begin
      d = $random(seed);
      u = $random(seed);
      wr(`OFS_PAUSE_SA_LOWER, d, 10'h000);
      wr(8'h40, ~u, 10'h000);
      wr(`OFS_PAUSE_SA_UPPER, u, 10'h000);
      rd(`OFS_PAUSE_SA_LOWER, {8'h00, d[23:0]});
      rd(`OFS_PAUSE_SA_UPPER, {8'h00, u[23:0]});
      `CHK(pauseSourceAddr, {u[23:0], d[23:0]})
    end
    $display("address halves done");
    wr(`OFS_EVENT_MASK, 32'hFFFF_FFFF, 10'h000);
    rd(`OFS_EVENT_MASK, 32'h0000_03FF);
    for (int i = 0; i < 10; i++) begin
      wr(8'h40, 32'h0000_0000, 10'h001 << i);
      rd(`OFS_EVENT_FLAGS, {22'h0, expF});
      wr(`OFS_EVENT_FLAGS, 32'hFFFF_FFFF, 10'h000);
    end
    $display("single events done");
    wr(`OFS_EVENT_FLAGS, 32'h0000_0020, 10'h020);
    wr(`OFS_EVENT_FLAGS, 32'h0000_0000, 10'h000);
    rd(`OFS_EVENT_FLAGS, {22'h0, expF});
    repeat (40) begin
      d = $random(seed);
      wr(d[31] ? `OFS_EVENT_MASK : `OFS_EVENT_FLAGS, $random(seed), d[9:0]);
      rd(`OFS_EVENT_FLAGS, {22'h0, expF});
    end
    wr(`OFS_EVENT_MASK, 32'h0000_0000, 10'h000);
    wr(`OFS_EVENT_FLAGS, 32'hFFFF_FFFF, 10'h000);
    rd(`OFS_EVENT_FLAGS, 32'h0000_0000);
    $display("random traffic done");
    summarize();
  end
endmodule : testbench
`default_nettype wire
